// File: rtl/pbs_sram_ctrl.sv
// Control logic and array of a pipelined burst SRAM
//
// What this block does
// - Address taken only on a strobe while all three chip selects are active.
// - Low two address bits seed a 2-bit wrapping burst counter for array address.
// - Each lane with its select low is written while the byte write gate is low.
// - Global write low writes every lane, ignoring lane selects and byte gate.
// - Burst counter steps on each edge of an access where the advance input is low and no strobe is taken.
// - First chip select active low; processor strobe ignored while it is high.
// - Second chip select is active high and takes part in selection.
// - Third chip select is active low and takes part in selection.
// - Output enable low drives the data lanes; high floats them for write data.
// - First read clock after deselection keeps the lanes undriven despite enable.
// - Processor strobe low captures full address and loads counter from low bits.
// - Controller strobe low captures full address and loads counter from low bits.
// - With both strobes low and the first select low, the processor strobe alone is acted upon.
// - Strap low picks linear order, high picks interleaved; static in use.
// - Read data shows the location addressed at the previous edge; writes registered.
`timescale 1ns/100ps
module pbs_sram_ctrl
    import pbs_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Address
    input  wire logic [HIGH_W-1:0] addr_high,
    input  wire logic              addr_low_bit1,
    input  wire logic              addr_low_bit0,
    // Address strobes and burst control
    input  wire logic              processor_addr_strobe_n,
    input  wire logic              controller_addr_strobe_n,
    input  wire logic              burst_advance_n,
    // Write controls
    input  wire logic              byte_write_gate_n,
    input  wire logic              all_lanes_write_n,
    input  wire logic [LANES-1:0]  byte_lane_select_n,
    // Chip selects
    input  wire logic              chip_select_first_n,
    input  wire logic              chip_select_second,
    input  wire logic              chip_select_third_n,
    // Asynchronous output enable and burst order strap
    input  wire logic              output_enable_n,
    input  wire logic              burst_order_strap,
    // Data lanes, split into input, output and enable
    input  wire logic [LANES*BYTE_W-1:0] dq_in,
    input  wire logic [LANES-1:0]        parity_lane_in,
    output logic      [LANES*BYTE_W-1:0] dq_out,
    output logic      [LANES-1:0]        parity_lane_out,
    output logic                         dq_oe,
    // Write buffer back-pressure towards the master
    output logic                         write_busy
);

    // Register state and its next value
    pbs_regs_t st;
    pbs_regs_t next_st;

    // Array storage, one word per location
    logic [WORD_W-1:0] mem [0:MEM_DEPTH-1];

    // Decoded pin conditions for this edge
    logic               proc_taken;
    logic               ctrl_taken;
    logic               strobe;
    logic               selected;
    logic [LANES-1:0]   write_lanes;
    logic               write_now;
    logic [ADDR_W-1:0]  cur_array_addr;
    logic [ADDR_W-1:0]  next_array_addr;
    logic [WORD_W-1:0]  write_word;

    // Drain side of the write buffer
    logic [ADDR_W-1:0]  drain_addr;
    logic [LANES-1:0]   drain_lanes;
    logic [WORD_W-1:0]  drain_data;
    logic [WORD_W-1:0]  drain_old;
    logic [WORD_W-1:0]  drain_merged;
    logic               drain_fire;

    pbs_fifo_if #(.WIDTH(ENTRY_W)) wbuf ();

    // Burst sequence: interleaved XORs, linear adds and wraps in the group
    function automatic logic [BURST_W-1:0] burst_low(
        input logic [BURST_W-1:0] start,
        input logic [BURST_W-1:0] step,
        input pbs_order_t         order
    );
        logic [BURST_W-1:0] res;
        if (order == PBS_INTERLEAVED) begin
            res = start ^ step;
        end else begin
            res = BURST_W'(start + step);
        end
        return res;
    endfunction : burst_low

    // Chip selects: first and third active low, second active high
    assign selected = !chip_select_first_n
                   && chip_select_second
                   && !chip_select_third_n;

    // Processor strobe counts only with the first select low, and wins a tie
    assign proc_taken = !processor_addr_strobe_n && !chip_select_first_n;
    assign ctrl_taken = !controller_addr_strobe_n && !proc_taken;
    assign strobe     = proc_taken || ctrl_taken;

    // Lane write decode; global write overrides the lane selects and gate
    always_comb begin : lane_decode
        if (!all_lanes_write_n) begin
            write_lanes = LANES_ALL;
        end else if (!byte_write_gate_n) begin
            write_lanes = ~byte_lane_select_n;
        end else begin
            write_lanes = LANES_NONE;
        end
    end

    assign write_now = (write_lanes != LANES_NONE);

    // Array address of the access now in the registers, and of the next one
    assign cur_array_addr  = {st.addr[ADDR_W-1:BURST_W],
                              burst_low(st.addr[BURST_W-1:0], st.count, st.order)};
    assign next_array_addr = {next_st.addr[ADDR_W-1:BURST_W],
                              burst_low(next_st.addr[BURST_W-1:0], next_st.count,
                                        st.order)};

    // Pack lanes and unpack the read word, parity bit on top of each lane
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        assign write_word[i*LANE_W +: LANE_W] = {parity_lane_in[i],
                                                 dq_in[i*BYTE_W +: BYTE_W]};
        assign dq_out[i*BYTE_W +: BYTE_W]     = st.rdata[i*LANE_W +: BYTE_W];
        assign parity_lane_out[i]             = st.rdata[i*LANE_W + BYTE_W];
        assign drain_merged[i*LANE_W +: LANE_W] = drain_lanes[i]
                                                ? drain_data[i*LANE_W +: LANE_W]
                                                : drain_old[i*LANE_W +: LANE_W];
    end

    assign dq_oe      = st.dq_oe;
    assign write_busy = st.busy;

    // Next state of the whole controller
    always_comb begin : next_state_logic
        next_st = st;

        // Three-stage synchronisers; a change counts once stages two and three agree
        next_st.oe_sync   = {st.oe_sync[SYNC_N-2:0], output_enable_n};
        next_st.mode_sync = {st.mode_sync[SYNC_N-2:0], burst_order_strap};
        if (st.oe_sync[1] == st.oe_sync[2]) begin
            next_st.oe_low = !st.oe_sync[2];
        end
        // The strap is meant to be static, so it is simply followed when settled
        if (st.mode_sync[1] == st.mode_sync[2]) begin
            next_st.order = st.mode_sync[2] ? PBS_INTERLEAVED : PBS_LINEAR;
        end

        // Mask only lasts for the first clock of the new access
        next_st.mask_oe = 1'b0;

        if (strobe) begin
            if (selected) begin
                // Start of an access: full address and counter seed together
                next_st.addr    = {addr_high, addr_low_bit1, addr_low_bit0};
                next_st.count   = COUNT_RST;
                next_st.mask_oe = (st.state == ST_DESEL);
                next_st.state   = write_now ? ST_WRITE : ST_READ;
            end else begin
                // A strobe with the chip not selected deselects it
                next_st.state = ST_DESEL;
            end
        end else begin
            case (st.state)
                ST_DESEL: begin
                    next_st.state = ST_DESEL;
                end
                ST_READ, ST_WRITE: begin
                    if (!burst_advance_n) begin
                        next_st.count = BURST_W'(st.count + 1'b1);
                    end
                    next_st.state = write_now ? ST_WRITE : ST_READ;
                end
                default: begin
                    next_st.state = ST_DESEL;
                end
            endcase
        end

        // Pipelined read: output register loads the word addressed one edge ago
        if (st.state == ST_READ) begin
            next_st.rdata = mem[cur_array_addr];
        end

        // Lanes drive only on a read while enable is low, but not on its first clock after deselection
        next_st.dq_oe = (st.state == ST_READ) && st.oe_low && !st.mask_oe;

        // Busy tells the master that a further write would not be taken
        next_st.busy = !wbuf.in_ready;
    end

    // Write data enters the buffer on the sampling edge with its lanes
    assign wbuf.in_valid = (next_st.state == ST_WRITE);
    assign wbuf.in_data  = {next_array_addr, write_lanes, write_word};

    // Reads own the array port, so the drain stalls while a read is pending
    assign wbuf.out_ready = (st.state != ST_READ);
    assign drain_fire     = wbuf.out_valid && wbuf.out_ready;
    assign drain_addr     = wbuf.out_data[ENT_ADDR_LSB +: ADDR_W];
    assign drain_lanes    = wbuf.out_data[ENT_LANE_LSB +: LANES];
    assign drain_data     = wbuf.out_data[ENT_DATA_LSB +: WORD_W];
    assign drain_old      = mem[drain_addr];

    pbs_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_write_buffer (
        .clk     (clk),
        .reset_n (reset_n),
        .f       (wbuf)
    );

    // Register the whole state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st <= REGS_RST;
        end else begin
            st <= next_st;
        end
    end

    // Lane merge keeps unselected lanes; the array itself is not reset
    always_ff @(posedge clk) begin
        if (drain_fire) begin
            mem[drain_addr] <= drain_merged;
        end
    end

endmodule : pbs_sram_ctrl

// File: rtl/pbs_pkg.sv
// Shared constants and types for the pipelined burst SRAM control block
package pbs_pkg;

    // Array geometry: four lanes of eight data bits plus one parity bit
    localparam int ADDR_W     = 18;
    localparam int LANES      = 4;
    localparam int BYTE_W     = 8;
    localparam int LANE_W     = 9;
    localparam int WORD_W     = LANES * LANE_W;
    localparam int HIGH_W     = ADDR_W - 2;
    localparam int MEM_DEPTH  = 262144;
    localparam int BURST_W    = 2;

    // Write buffer in front of the array
    localparam int FIFO_DEPTH = 8;
    localparam int ENT_DATA_LSB = 0;
    localparam int ENT_LANE_LSB = WORD_W;
    localparam int ENT_ADDR_LSB = WORD_W + LANES;
    localparam int ENTRY_W      = ADDR_W + LANES + WORD_W;

    // Depth of the synchroniser on the asynchronous pins
    localparam int SYNC_N = 3;

    // Reset values
    localparam logic [ADDR_W-1:0]  ADDR_RST  = 18'h0_0000;
    localparam logic [BURST_W-1:0] COUNT_RST = 2'h0;
    localparam logic [LANES-1:0]   LANES_ALL = 4'hf;
    localparam logic [LANES-1:0]   LANES_NONE = 4'h0;

    // Burst order selected by the strap
    typedef enum logic {
        PBS_LINEAR      = 1'b0,
        PBS_INTERLEAVED = 1'b1
    } pbs_order_t;

    // Access state of the device
    typedef enum logic [1:0] {
        ST_DESEL = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } pbs_access_t;

    // Whole register state of the controller
    typedef struct packed {
        logic [ADDR_W-1:0]  addr;
        logic [BURST_W-1:0] count;
        pbs_access_t        state;
        logic               mask_oe;
        logic [SYNC_N-1:0]  oe_sync;
        logic [SYNC_N-1:0]  mode_sync;
        logic               oe_low;
        pbs_order_t         order;
        logic [WORD_W-1:0]  rdata;
        logic               dq_oe;
        logic               busy;
    } pbs_regs_t;

    localparam pbs_regs_t REGS_RST = '{
        addr:      ADDR_RST,
        count:     COUNT_RST,
        state:     ST_DESEL,
        mask_oe:   1'b0,
        oe_sync:   3'h7,
        mode_sync: 3'h7,
        oe_low:    1'b0,
        order:     PBS_INTERLEAVED,
        rdata:     36'h0_0000_0000,
        dq_oe:     1'b0,
        busy:      1'b0
    };

endpackage : pbs_pkg

// File: rtl/pbs_fifo_if.sv
// Valid/ready carrier between the controller and its write buffer
`timescale 1ns/100ps
interface pbs_fifo_if #(
    parameter int WIDTH = 8
);
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] in_data;
    logic             out_valid;
    logic             out_ready;
    logic [WIDTH-1:0] out_data;

    // Buffer side
    modport buffer (
        input  in_valid,
        input  in_data,
        input  out_ready,
        output in_ready,
        output out_valid,
        output out_data
    );

    // User side: fills and drains the buffer
    modport user (
        output in_valid,
        output in_data,
        output out_ready,
        input  in_ready,
        input  out_valid,
        input  out_data
    );
endinterface : pbs_fifo_if

// File: rtl/pbs_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module pbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Fill and drain
    pbs_fifo_if.buffer f
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W:0]   level;
    logic             push;
    logic             pop;

    // Full and empty come straight from the fill level
    assign f.in_ready  = (level != (PTR_W+1)'(DEPTH));
    assign f.out_valid = (level != '0);
    assign f.out_data  = store[rd_ptr];
    assign push        = f.in_valid && f.in_ready;
    assign pop         = f.out_valid && f.out_ready;

    // Pointers wrap naturally because the depth is a power of two
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            level  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            level <= level + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

    // Storage needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= f.in_data;
        end
    end

endmodule : pbs_fifo

// File: test/pbs_sram_ctrl_properties.sv
// Concurrent checks on the pins of the burst SRAM control block
`timescale 1ns/100ps
module pbs_props
    import pbs_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              reset_n,
    // Strobes and write controls
    input wire logic              processor_addr_strobe_n,
    input wire logic              controller_addr_strobe_n,
    input wire logic              byte_write_gate_n,
    input wire logic              all_lanes_write_n,
    input wire logic [LANES-1:0]  byte_lane_select_n,
    // Chip selects and output enable
    input wire logic              chip_select_first_n,
    input wire logic              chip_select_second,
    input wire logic              chip_select_third_n,
    input wire logic              output_enable_n,
    // Outputs
    input wire logic [LANES*BYTE_W-1:0] dq_out,
    input wire logic [LANES-1:0]        parity_lane_out,
    input wire logic                    dq_oe,
    input wire logic                    write_busy
);
    logic taken, sel, wr, desel, selrd, contrd, idle_st;

    // Decoded view of one sampled edge; outputs lag a read by two samples
    assign taken  = (!processor_addr_strobe_n && !chip_select_first_n)
                 || !controller_addr_strobe_n;
    assign sel    = !chip_select_first_n && chip_select_second && !chip_select_third_n;
    assign wr     = !all_lanes_write_n || (!byte_write_gate_n && !(&byte_lane_select_n));
    assign desel  = taken && !sel;
    assign selrd  = taken && sel && !wr;
    assign contrd = processor_addr_strobe_n && controller_addr_strobe_n && !wr;

    // Mirror of the deselected state; quiet edges keep it, so a long idle still counts
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            idle_st <= 1'b1;
        end else if (taken) begin
            idle_st <= !sel;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_desel_dark: assert property (desel |-> ##2 !dq_oe)
        else $error("lanes driven after deselect");
    a_desel_hold: assert property (desel |-> ##2 $stable({parity_lane_out, dq_out}))
        else $error("read data changed while deselected");
    a_first_masked: assert property (idle_st && selrd |-> ##2 !dq_oe)
        else $error("enable not masked on first read clock");
    a_read_drives: assert property (!output_enable_n [*4] ##0 selrd
        ##1 (contrd && !output_enable_n) ##1 !output_enable_n |=> dq_oe)
        else $error("lanes not driven during burst read");
    a_write_dark: assert property (taken && sel && !all_lanes_write_n |-> ##2 !dq_oe)
        else $error("lanes driven after global write");
    a_gate_dark: assert property (taken && sel && all_lanes_write_n && !byte_write_gate_n
        && !(&byte_lane_select_n) |-> ##2 !dq_oe)
        else $error("lanes driven after byte write");
    a_oe_float: assert property (output_enable_n [*4] |-> ##2 !dq_oe)
        else $error("lanes driven with enable high");
    a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> !dq_oe && !write_busy)
        else $error("outputs active in reset");
endmodule : pbs_props

bind pbs_sram_ctrl pbs_props u_props (
    .clk(clk), .reset_n(reset_n),
    .processor_addr_strobe_n(processor_addr_strobe_n),
    .controller_addr_strobe_n(controller_addr_strobe_n),
    .byte_write_gate_n(byte_write_gate_n), .all_lanes_write_n(all_lanes_write_n),
    .byte_lane_select_n(byte_lane_select_n), .chip_select_first_n(chip_select_first_n),
    .chip_select_second(chip_select_second), .chip_select_third_n(chip_select_third_n),
    .output_enable_n(output_enable_n), .dq_out(dq_out), .parity_lane_out(parity_lane_out),
    .dq_oe(dq_oe), .write_busy(write_busy)
);

// File: test/pbs_master.sv
// Bus master model driving the synchronous pins of the SRAM control block
`timescale 1ns/100ps
module pbs_master
    import pbs_pkg::*;
(
    // Clock
    input  wire logic         clk,
    // Address, strobes and burst control
    output logic [HIGH_W-1:0] addr_high,
    output logic              addr_low_bit1,
    output logic              addr_low_bit0,
    output logic              processor_addr_strobe_n,
    output logic              controller_addr_strobe_n,
    output logic              burst_advance_n,
    // Write controls and data
    output logic              byte_write_gate_n,
    output logic              all_lanes_write_n,
    output logic [LANES-1:0]  byte_lane_select_n,
    output logic [LANES*BYTE_W-1:0] dq_in,
    output logic [LANES-1:0]  parity_lane_in,
    // Chip selects
    output logic              chip_select_first_n,
    output logic              chip_select_second,
    output logic              chip_select_third_n,
    // Marks an edge whose result the bench will check
    output logic              mark
);
    // Idle at time zero: strobes released, chip deselected
    initial begin
        {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
        {byte_write_gate_n, all_lanes_write_n, byte_lane_select_n} = 6'h3f;
        {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h0;
        {addr_high, addr_low_bit1, addr_low_bit0} = 18'h0_0000;
        {parity_lane_in, dq_in} = 36'h0_0000_0000;
        mark = 1'b0;
    end

    // One bus edge; pins change 1 ns after the edge and hold until the next
    task automatic step(input logic [1:0] st_n, input logic adv_n, input logic [1:0] wr_n,
                        input logic [3:0] lanes_n, input logic [2:0] cs,
                        input logic [17:0] a, input logic [35:0] d, input logic mk);
        @(posedge clk);
        #1;
        {processor_addr_strobe_n, controller_addr_strobe_n} = st_n;
        burst_advance_n = adv_n;
        {byte_write_gate_n, all_lanes_write_n} = wr_n;
        byte_lane_select_n = lanes_n;
        {chip_select_first_n, chip_select_second, chip_select_third_n} = cs;
        {addr_high, addr_low_bit1, addr_low_bit0} = a;
        {parity_lane_in, dq_in} = d;
        mark = mk;
    endtask : step
endmodule : pbs_master

// File: test/pbs_sram_ctrl_tb.sv
// Self-checking bench for the pipelined burst SRAM control block
`timescale 1ns/100ps
module pbs_sram_ctrl_tb
    import pbs_pkg::*;
;
    localparam logic [2:0] SEL = 3'h2;
    localparam logic [2:0] DSEL = 3'h0;
    logic clk, reset_n, output_enable_n, burst_order_strap, mark, dq_oe, write_busy;
    logic a1, a0, ps_n, cs_n, adv_n, gate_n, all_n, c1_n, c2, c3_n;
    logic [HIGH_W-1:0] addr_high;
    logic [3:0] lanes_n, par_in, parity_lane_out, lanes;
    logic [31:0] dq_in, dq_out;
    logic [1:0] pipe = 2'h0;
    logic [1:0] s;
    logic [15:0] base;
    logic [35:0] d, w;
    logic [36:0] e;
    logic [36:0] exp_q[$];
    logic [35:0] mem [logic [17:0]];
    logic lin;
    int pass, k, i, cycles, failures, n_compared;
    int unsigned seed;

    pbs_sram_ctrl DUT (.clk(clk), .reset_n(reset_n), .addr_high(addr_high),
        .addr_low_bit1(a1), .addr_low_bit0(a0), .processor_addr_strobe_n(ps_n),
        .controller_addr_strobe_n(cs_n), .burst_advance_n(adv_n),
        .byte_write_gate_n(gate_n), .all_lanes_write_n(all_n), .byte_lane_select_n(lanes_n),
        .chip_select_first_n(c1_n), .chip_select_second(c2), .chip_select_third_n(c3_n),
        .output_enable_n(output_enable_n), .burst_order_strap(burst_order_strap),
        .dq_in(dq_in), .parity_lane_in(par_in), .dq_out(dq_out),
        .parity_lane_out(parity_lane_out), .dq_oe(dq_oe), .write_busy(write_busy));
    pbs_master m (.clk(clk), .addr_high(addr_high), .addr_low_bit1(a1), .addr_low_bit0(a0),
        .processor_addr_strobe_n(ps_n), .controller_addr_strobe_n(cs_n),
        .burst_advance_n(adv_n), .byte_write_gate_n(gate_n), .all_lanes_write_n(all_n),
        .byte_lane_select_n(lanes_n), .dq_in(dq_in), .parity_lane_in(par_in),
        .chip_select_first_n(c1_n), .chip_select_second(c2), .chip_select_third_n(c3_n),
        .mark(mark));

    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [1:0] nth(input logic ln, input logic [1:0] st, input logic [1:0] n);
        return ln ? st + n : st ^ n;
    endfunction : nth

    function automatic logic [35:0] rnd36();
        return {4'($urandom), $urandom};
    endfunction : rnd36

    // Deselect, then leave the bus quiet so the write buffer can drain
    task automatic idle(input int n);
        m.step(2'b10, 1'b1, 2'b11, 4'hf, DSEL, 18'h0_0000, rnd36(), 1'b0);
        repeat (n) m.step(2'b11, 1'b1, 2'b11, 4'hf, DSEL, 18'h0_0000, rnd36(), 1'b0);
    endtask : idle

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // Read data appears two samples after its marked edge; the buffer never fills here
    always @(posedge clk) begin
        if (pipe[1]) begin
            e = exp_q.pop_front();
            n_compared++;
            if ({write_busy, dq_oe, parity_lane_out, dq_out} !== {1'b0, e}) begin
                failures++;
                $display("[ERR] %0t read word, lane enable or busy mismatch", $time);
            end
        end
        pipe <= {pipe[0], mark};
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            final_report();
        end
    end

    initial begin
        seed = $urandom(49424);
        reset_n = 1'b0;
        output_enable_n = 1'b1;
        burst_order_strap = 1'b1;
        for (pass = 0; pass < 2; pass++) begin
            lin = pass[0];
            burst_order_strap = !lin;
            reset_n = 1'b0;
            output_enable_n = 1'b1;
            repeat (10) @(posedge clk);
            #1 reset_n = 1'b1;
            idle(6);
            output_enable_n = 1'b0;
            // Burst write of a whole group with the global write
            base = 16'($urandom);
            for (k = 0; k < 4; k++) begin
                d = rnd36();
                mem[{base, nth(lin, 2'h0, k[1:0])}] = d;
                m.step(k == 0 ? 2'b01 : 2'b11, k == 0, 2'b10, 4'hf, SEL,
                       {base, 2'h0}, d, 0);
            end
            idle(12);
            // Per-lane write through the controller strobe
            s = 2'($urandom_range(3, 1));
            lanes = 4'($urandom) & 4'hb;
            d = rnd36();
            w = mem[{base, s}];
            for (i = 0; i < 4; i++) begin
                if (!lanes[i]) begin
                    w[8*i +: 8] = d[8*i +: 8];
                    w[32+i] = d[32+i];
                end
            end
            mem[{base, s}] = w;
            m.step(2'b10, 1'b1, 2'b01, lanes, SEL, {base, s}, d, 1'b0);
            idle(12);
            // Burst read from a random start, both strobes on the first edge
            // Third edge: processor strobe with the first select high must not end the burst
            s = 2'($urandom_range(3, 1));
            for (k = 0; k < 4; k++) begin
                exp_q.push_back({k != 0, mem[{base, nth(lin, s, k[1:0])}]});
                m.step(k == 0 ? 2'b00 : {k != 2, 1'b1}, k == 0, 2'b11, 4'hf,
                       k == 2 ? 3'h6 : SEL, {base, s}, rnd36(), 1);
            end
            m.step(2'b10, 1'b1, 2'b11, 4'hf, DSEL, 18'h0_0000, rnd36(), 1'b0);
            // Processor strobe with the first select high starts nothing
            exp_q.push_back({1'b0, mem[{base, nth(lin, s, 2'h3)}]});
            m.step(2'b01, 1'b1, 2'b11, 4'hf, 3'h6, 18'($urandom), rnd36(), 1'b1);
            idle(3);
        end
        final_report();
    end
endmodule : pbs_sram_ctrl_tb
